// [core/hwr_map.vh]
// Constants for the halt, wake-up and reset controller
`ifndef HWR_MAP_VH
`define HWR_MAP_VH

// Port widths
`define HWR_PA_W 8
`define HWR_IO_W 10
`define HWR_NINT 4

// Start-up timer: 1024 system clock periods
`define HWR_SST_W 10
`define HWR_SST_CYCLES 1024
`define HWR_SST_LAST 10'h3FF

// Interrupt-entry delay count, loaded after the start-up wait; entry lags a plain resume by 3 cycles
`define HWR_INT_EXTRA 2'h2

// Reset values
`define HWR_IO_DIR_RST 10'h3FF
`define HWR_IO_DAT_RST 10'h3FF
`define HWR_SYNC_RST 10'h3FF
`define HWR_FLAG_RST 1'h0

`endif

// [core/hwr_sync.v]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "hwr_map.vh"

module hwr_sync (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Asynchronous levels in, synchronised levels out
  input wire [`HWR_IO_W-1:0] i_async,
  output reg [`HWR_IO_W-1:0] o_sync
);

  reg [`HWR_IO_W-1:0] meta_q;

  // Idle-high reset value so released pins do not look like events
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= `HWR_SYNC_RST;
      o_sync <= `HWR_SYNC_RST;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// [core/hwr_sst.v]
// Start-up stabilisation timer: fixed wait after power-up or wake-up
`timescale 1ns/1ps
`include "hwr_map.vh"

module hwr_sst (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Control
  input wire i_start,
  // Status
  output wire o_busy,
  output reg o_done
);

  reg [`HWR_SST_W-1:0] cnt_q;
  reg busy_q;

  assign o_busy = busy_q;

  // Busy out of reset: power-up gets the same wait as a wake-up
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= {`HWR_SST_W{1'b0}};
      busy_q <= 1'b1;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_q <= {`HWR_SST_W{1'b0}};
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == `HWR_SST_LAST) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(`HWR_SST_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// [core/hwr_ctrl.v]
// Halt, wake-up and reset sequencing for a small 8-bit microcontroller
`timescale 1ns/1ps
`include "hwr_map.vh"

// Contract
// - Halt stops system oscillator; RC keeps running
// - Halt freezes RAM and register contents
// - Halt clears watchdog when RC-clocked
// - Ports hold direction and output during halt
// - Halt sets power-down flag, clears time-out flag
// - LCD runs in halt only if enabled
// - Wake on reset, interrupt, port edge, watchdog
// - Watchdog wake does warm reset: PC, SP
// - Power-down flag: cleared by clear instruction, power-up
// - Watchdog time-out sets time-out flag
// - Each port A bit enables its wake-up
// - Port wake resumes at next instruction
// - Interrupt wake: next instruction or interrupt response
// - Pending-before-halt interrupt cannot wake device
// - Wake-up waits 1024 clocks; interrupt later
// - Power-up also waits 1024 clocks
// - Flags encode the cause of reset
// - Chip reset restores functional unit defaults
// - Chip reset clears watchdog; restarts after release
// - Watchdog overflow when running: full chip reset
module hwr_ctrl (
  // Clock and power-up reset
  input wire i_mclk,
  input wire i_reset,
  // External pins (asynchronous)
  input wire i_ext_reset_pin_n,
  input wire [`HWR_PA_W-1:0] i_porta,
  input wire i_wdt_overflow,
  // CPU events
  input wire i_halt_exec,
  input wire i_watchdog_clear_instruction,
  // Interrupt state from the core
  input wire [`HWR_NINT-1:0] i_int_req,
  input wire [`HWR_NINT-1:0] i_int_enable,
  input wire i_global_int_en,
  input wire i_stack_full,
  // Configuration options
  input wire [`HWR_PA_W-1:0] i_porta_wake_en,
  input wire i_rc_osc_select,
  input wire i_wdt_rc_select,
  input wire i_lcd_rc_clock_enable,
  // Port state from the core
  input wire [`HWR_IO_W-1:0] i_io_dir,
  input wire [`HWR_IO_W-1:0] i_io_data,
  // Clock control
  output wire o_sys_osc_en,
  output wire o_internal_rc_oscillator_en,
  output wire o_lcd_run,
  // Core control
  output wire o_core_hold,
  output reg o_chip_reset,
  output reg o_warm_reset,
  output reg o_resume_next,
  output reg o_int_entry,
  // Watchdog control
  output reg o_wdt_clear,
  output wire o_wdt_run,
  // Reset-cause flags
  output reg o_power_down_flag,
  output reg o_timeout_flag,
  // Held port state
  output reg [`HWR_IO_W-1:0] o_io_dir,
  output reg [`HWR_IO_W-1:0] o_io_data
);

  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_HALT = 3'h1;
  localparam [2:0] ST_SST = 3'h2;
  localparam [2:0] ST_PINRST = 3'h3;
  localparam [2:0] ST_INTDLY = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`HWR_NINT-1:0] armed_q;
  reg [`HWR_PA_W-1:0] pa_prev_q;
  reg wdt_prev_q;
  reg from_halt_q;
  reg int_pend_q;
  reg [1:0] dly_q;

  wire [`HWR_IO_W-1:0] sync_out;
  wire rst_pin_n_s;
  wire wdt_s;
  wire [`HWR_PA_W-1:0] pa_s;
  wire sst_busy;
  wire sst_done;
  reg sst_start;

  // True on the edge that carries the sequencer from one given state to another
  function moves;
    input [2:0] cur;
    input [2:0] nxt;
    input [2:0] from_st;
    input [2:0] to_st;
    begin
      moves = (cur == from_st) && (nxt == to_st);
    end
  endfunction

  // Pins cross into the always-running clock before any logic sees them
  // Every pin event therefore acts two cycles after it reaches the pin
  hwr_sync u_sync (
    .i_mclk (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_ext_reset_pin_n, i_wdt_overflow, i_porta}),
    .o_sync (sync_out)
  );

  assign rst_pin_n_s = sync_out[`HWR_IO_W-1];
  assign wdt_s = sync_out[`HWR_IO_W-2];
  assign pa_s = sync_out[`HWR_PA_W-1:0];

  hwr_sst u_sst (
    .i_mclk (i_mclk),
    .i_reset (i_reset),
    .i_start (sst_start),
    .o_busy (sst_busy),
    .o_done (sst_done)
  );

  // Event decode
  wire pin_rst = ~rst_pin_n_s;
  wire wdt_ovf = wdt_s & ~wdt_prev_q;
  wire [`HWR_PA_W-1:0] pa_fall = pa_prev_q & ~pa_s & i_porta_wake_en;
  wire port_wake = |pa_fall;
  wire [`HWR_NINT-1:0] int_live = i_int_req & armed_q;
  wire int_wake = |int_live;
  wire int_go = (|(int_live & i_int_enable)) & i_global_int_en & ~i_stack_full;
  wire halted = (state_q == ST_HALT);
  wire running = (state_q == ST_RUN);
  // Sequencer transitions that the register processes act on
  wire halt_go = moves(state_q, state_d, ST_RUN, ST_HALT);
  wire wake_go = moves(state_q, state_d, ST_HALT, ST_SST);
  wire int_dly_go = moves(state_q, state_d, ST_SST, ST_INTDLY);

  // The core only steps in the run state, so nothing it owns can change
  assign o_core_hold = ~running;
  assign o_sys_osc_en = ~halted;
  assign o_internal_rc_oscillator_en = i_rc_osc_select;
  assign o_lcd_run = ~halted | i_lcd_rc_clock_enable;
  // An instruction-clocked watchdog stops with the system clock in halt
  assign o_wdt_run = ~o_chip_reset & (~halted | i_wdt_rc_select);

  // Next-state decision
  always @* begin
    state_d = state_q;
    sst_start = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (pin_rst) begin
          state_d = ST_PINRST;
        end else if (!wdt_ovf && i_halt_exec) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (pin_rst) begin
          state_d = ST_PINRST;
        end else if (wdt_ovf || int_wake || port_wake) begin
          state_d = ST_SST;
          sst_start = 1'b1;
        end
      end
      ST_SST: begin
        if (sst_done) begin
          state_d = int_pend_q ? ST_INTDLY : ST_RUN;
        end
      end
      ST_PINRST: begin
        if (!pin_rst) begin
          // Taken in halt, the pin still owes the oscillator its start-up wait
          if (from_halt_q) begin
            state_d = ST_SST;
            sst_start = 1'b1;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_INTDLY: begin
        // Interrupt entry lags a plain resume by a fixed few cycles
        if (dly_q == 2'h0) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_SST;
      armed_q <= {`HWR_NINT{1'b0}};
      pa_prev_q <= {`HWR_PA_W{1'b1}};
      wdt_prev_q <= 1'b1;
      from_halt_q <= 1'b0;
      int_pend_q <= 1'b0;
      dly_q <= 2'h0;
    end else begin
      state_q <= state_d;
      pa_prev_q <= pa_s;
      wdt_prev_q <= wdt_s;
      if (halt_go) begin
        // Requests already pending at halt are not allowed to wake
        armed_q <= ~i_int_req;
      end else if (halted) begin
        // A source whose old request drops may wake once it is raised anew
        armed_q <= armed_q | ~i_int_req;
      end
      if (state_q != ST_PINRST && state_d == ST_PINRST) begin
        from_halt_q <= halted;
      end
      // Watchdog and port wakes always take the plain resume path
      if (wake_go) begin
        int_pend_q <= ~wdt_ovf & ~port_wake & int_wake & int_go;
      end else if (state_q == ST_PINRST) begin
        int_pend_q <= 1'b0;
      end
      if (int_dly_go) begin
        dly_q <= `HWR_INT_EXTRA;
      end else if (state_q == ST_INTDLY && dly_q != 2'h0) begin
        dly_q <= dly_q - 2'h1;
      end
    end
  end

  // Reset strobes and resume pulses
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_chip_reset <= 1'b1;
      o_warm_reset <= 1'b0;
      o_resume_next <= 1'b0;
      o_int_entry <= 1'b0;
    end else begin
      o_warm_reset <= 1'b0;
      o_resume_next <= 1'b0;
      o_int_entry <= 1'b0;
      case (state_q)
        ST_RUN: begin
          // Running overflow resets the whole chip for one cycle
          o_chip_reset <= pin_rst | wdt_ovf;
        end
        ST_HALT: begin
          o_chip_reset <= pin_rst;
          o_warm_reset <= ~pin_rst & wdt_ovf;
        end
        ST_SST: begin
          if (sst_done) begin
            o_chip_reset <= 1'b0;
            o_resume_next <= ~int_pend_q;
          end
        end
        ST_PINRST: begin
          o_chip_reset <= pin_rst | from_halt_q;
        end
        ST_INTDLY: begin
          o_int_entry <= (dly_q == 2'h0);
        end
        default: begin
          o_chip_reset <= 1'b1;
        end
      endcase
    end
  end

  // Watchdog clear strobe
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_wdt_clear <= 1'b1;
    end else begin
      // The strobe stands for as long as the reset pin holds the sequencer in its pin reset state
      o_wdt_clear <= (state_d == ST_PINRST)
        | (halt_go && i_wdt_rc_select)
        | (running && i_watchdog_clear_instruction)
        | (running && wdt_ovf);
    end
  end

  // Reset-cause flags; a set in the same cycle as a clear wins, except that a pin reset in halt clears the time-out flag over an overflow
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_power_down_flag <= `HWR_FLAG_RST;
      o_timeout_flag <= `HWR_FLAG_RST;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (pin_rst) begin
            o_power_down_flag <= o_power_down_flag;
          end else if (wdt_ovf) begin
            o_timeout_flag <= 1'b1;
          end else if (i_halt_exec) begin
            o_power_down_flag <= 1'b1;
            o_timeout_flag <= 1'b0;
          end else if (i_watchdog_clear_instruction) begin
            o_power_down_flag <= 1'b0;
          end
        end
        ST_HALT: begin
          if (pin_rst) begin
            o_timeout_flag <= 1'b0;
            o_power_down_flag <= 1'b1;
          end else if (wdt_ovf) begin
            o_timeout_flag <= 1'b1;
            o_power_down_flag <= 1'b1;
          end
        end
        default: begin
          // An overflow outside a chip reset still marks a time-out
          if (wdt_ovf && !o_chip_reset) begin
            o_timeout_flag <= 1'b1;
          end
        end
      endcase
    end
  end

  // Port direction and data: input mode on chip reset, frozen in halt
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_io_dir <= `HWR_IO_DIR_RST;
      o_io_data <= `HWR_IO_DAT_RST;
    end else if (o_chip_reset) begin
      o_io_dir <= `HWR_IO_DIR_RST;
      o_io_data <= `HWR_IO_DAT_RST;
    end else if (running) begin
      o_io_dir <= i_io_dir;
      o_io_data <= i_io_data;
    end else begin
      // Held from the last running cycle; warm reset leaves ports alone
      o_io_dir <= o_io_dir;
      o_io_data <= o_io_data;
    end
  end

endmodule

// [sim/hwr_core_model.sv]
// Core-side port registers that feed the controller
`timescale 1ns/1ps
module hwr_core_model (
  input wire i_mclk,
  input wire i_chip_reset,
  input wire i_wr,
  input wire [9:0] i_dir,
  input wire [9:0] i_dat,
  output reg [9:0] o_io_dir,
  output reg [9:0] o_io_data
);
  // Writes are taken even while the core is held, so the bench can prove the freeze
  always @(posedge i_mclk or posedge i_chip_reset) begin
    if (i_chip_reset) begin
      o_io_dir <= 10'h3FF;
      o_io_data <= 10'h3FF;
    end else if (i_wr) begin
      o_io_dir <= i_dir;
      o_io_data <= i_dat;
    end
  end
endmodule

// [sim/hwr_ctrl_asserts.sv]
// Concurrent checks on the halt, wake-up and reset controller ports
`timescale 1ns/1ps
`include "hwr_map.vh"
module hwr_ctrl_chk (
  input wire i_mclk, i_reset, i_ext_reset_pin_n, i_wdt_overflow, i_halt_exec,
  input wire i_watchdog_clear_instruction, i_rc_osc_select, i_wdt_rc_select,
  input wire i_lcd_rc_clock_enable, o_sys_osc_en, o_internal_rc_oscillator_en,
  input wire o_lcd_run, o_core_hold, o_chip_reset, o_warm_reset, o_wdt_clear,
  input wire o_wdt_run, o_power_down_flag, o_timeout_flag,
  input wire [`HWR_IO_W-1:0] o_io_dir,
  input wire [`HWR_IO_W-1:0] o_io_data
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  reg [10:0] cnt_q;
  // Only cycles with the oscillator up count, so time spent halted is left out
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) cnt_q <= 11'h000;
    else if (!o_core_hold || !o_sys_osc_en || !i_ext_reset_pin_n) cnt_q <= 11'h000;
    else cnt_q <= cnt_q + 11'h001;
  end
  reg sleep_q;
  // A pin reset while running has no start-up wait; only power-up and halt are timed
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) sleep_q <= 1'b1;
    else if (!o_sys_osc_en) sleep_q <= 1'b1;
    else if (!o_core_hold) sleep_q <= 1'b0;
  end
  sequence s_quiet;
    (i_ext_reset_pin_n && !i_wdt_overflow)[*4];
  endsequence
  sequence s_halt;
    s_quiet ##0 (i_halt_exec && !o_core_hold);
  endsequence
  a_halt_flags: assert property (s_halt |=> !o_sys_osc_en && o_power_down_flag && !o_timeout_flag)
    else $error("halt entry flags or oscillator wrong");
  a_halt_wdt_clear: assert property (s_halt ##0 i_wdt_rc_select |=> o_wdt_clear)
    else $error("watchdog not cleared on halt");
  a_rc_osc_en: assert property (o_internal_rc_oscillator_en == i_rc_osc_select)
    else $error("rc oscillator enable wrong");
  a_lcd_run_gate: assert property (o_lcd_run == (o_sys_osc_en || i_lcd_rc_clock_enable))
    else $error("lcd run wrong");
  a_wdt_run_gate: assert property (o_wdt_run == (!o_chip_reset && (o_sys_osc_en || i_wdt_rc_select)))
    else $error("watchdog run wrong");
  a_ports_frozen: assert property (!o_sys_osc_en && $past(!o_sys_osc_en) && !o_chip_reset
    |-> $stable(o_io_dir) && $stable(o_io_data))
    else $error("ports moved while halted");
  a_wake_wait: assert property ($fell(o_core_hold) && sleep_q |-> cnt_q >= 11'h3FA && cnt_q <= 11'h408)
    else $error("start-up wait length wrong");
  a_warm_flags: assert property (o_warm_reset |-> !o_chip_reset ##[0:1] (o_timeout_flag && o_power_down_flag))
    else $error("warm reset flags wrong");
  a_clear_pdf: assert property (s_quiet ##0 (i_watchdog_clear_instruction && !o_core_hold && !i_halt_exec)
    |=> !o_power_down_flag)
    else $error("power-down flag not cleared");
  a_run_wdt_reset: assert property ($rose(i_wdt_overflow) && !o_core_hold && !o_chip_reset && i_ext_reset_pin_n
    |-> ##[2:5] o_chip_reset ##[0:1] o_timeout_flag)
    else $error("running overflow gave no chip reset");
endmodule
bind hwr_ctrl hwr_ctrl_chk u_hwr_ctrl_chk (.i_mclk, .i_reset, .i_ext_reset_pin_n, .i_wdt_overflow,
  .i_halt_exec, .i_watchdog_clear_instruction, .i_rc_osc_select, .i_wdt_rc_select,
  .i_lcd_rc_clock_enable, .o_sys_osc_en, .o_internal_rc_oscillator_en, .o_lcd_run, .o_core_hold,
  .o_chip_reset, .o_warm_reset, .o_wdt_clear, .o_wdt_run, .o_power_down_flag, .o_timeout_flag,
  .o_io_dir, .o_io_data);

// [sim/hwr_ctrl_bench.sv]
// Self-checking bench for the halt, wake-up and reset controller
`timescale 1ns/1ps
module hwr_ctrl_bench;
  reg i_mclk = 0, rst = 1, pin_n = 1, wdt = 0, halt = 0, clr = 0, gie = 1, sfull = 0;
  reg rcsel = 1, wrc = 1, lcden = 0, mwr = 0;
  reg [7:0] pa = 8'hFF, wen = 8'h0F;
  reg [3:0] ireq = 4'h0, ien = 4'hF;
  reg [9:0] md = 10'h000, mdat = 10'h000;
  wire [9:0] cdir, cdat, o_io_dir, o_io_data;
  wire osc, rco, lcd, hold, crst, warm, res, ient, wclr, wrun, power_down_flag, to;
  int n_mismatch = 0, cmp_count = 0, n, k;
  reg sr, si, sw;
  always #50 i_mclk = ~i_mclk;
  hwr_core_model u_hwr_core_model (.i_mclk(i_mclk), .i_chip_reset(crst), .i_wr(mwr),
    .i_dir(md), .i_dat(mdat), .o_io_dir(cdir), .o_io_data(cdat));
  hwr_ctrl u_hwr_ctrl (.i_mclk(i_mclk), .i_reset(rst), .i_ext_reset_pin_n(pin_n), .i_porta(pa),
    .i_wdt_overflow(wdt), .i_halt_exec(halt), .i_watchdog_clear_instruction(clr),
    .i_int_req(ireq), .i_int_enable(ien), .i_global_int_en(gie), .i_stack_full(sfull),
    .i_porta_wake_en(wen), .i_rc_osc_select(rcsel), .i_wdt_rc_select(wrc),
    .i_lcd_rc_clock_enable(lcden), .i_io_dir(cdir), .i_io_data(cdat), .o_sys_osc_en(osc),
    .o_internal_rc_oscillator_en(rco), .o_lcd_run(lcd), .o_core_hold(hold),
    .o_chip_reset(crst), .o_warm_reset(warm), .o_resume_next(res), .o_int_entry(ient),
    .o_wdt_clear(wclr), .o_wdt_run(wrun), .o_power_down_flag(power_down_flag), .o_timeout_flag(to),
    .o_io_dir(o_io_dir), .o_io_data(o_io_data));
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task step(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask
  // Bounded wait for the core to be released, noting which pulses came out
  task wake;
    n = 0; sr = 0; si = 0; sw = 0;
    do begin
      @(posedge i_mclk); #1; n++;
      sr |= res; si |= ient; sw |= warm;
    end while (hold && n < 1200);
    if (n >= 1200) begin n_mismatch++; stop_test; end
  endtask
  task do_halt;
    @(posedge i_mclk); halt <= 1;
    @(posedge i_mclk); halt <= 0;
    #1;
  endtask
  task pulse_clr;
    @(posedge i_mclk); clr <= 1;
    @(posedge i_mclk); clr <= 0;
    step(1);
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    rst <= 0;
    step(1);
    chk("flags", {to, power_down_flag}, 2'b00);
    chk("io_dir", o_io_dir, 10'h3FF);
    chk("chip_reset", crst, 1'b1);
    wake;
    chk("powerup wait", n >= 1020 && n <= 1030, 1'b1);
    // Pins parked low before sleeping
    @(posedge i_mclk); mwr <= 1; md <= 10'h0A5; mdat <= 10'h000;
    @(posedge i_mclk); mwr <= 0; ireq <= 4'h1;
    step(3);
    do_halt;
    chk("halt flags", {to, power_down_flag, osc, lcd, rco}, 5'b01001);
    @(posedge i_mclk); mwr <= 1; md <= 10'h3FF; mdat <= 10'h3FF;
    @(posedge i_mclk); mwr <= 0; pa <= 8'hEF;
    step(8);
    chk("held dir", o_io_dir, 10'h0A5);
    chk("held data", o_io_data, 10'h000);
    chk("no wake", hold, 1'b1);
    @(posedge i_mclk); pa <= 8'hEE;
    wake;
    chk("port wait", n >= 1024 && n <= 1032, 1'b1);
    chk("port resume", {sr, si}, 2'b10);
    pa <= 8'hFF; ireq <= 4'h0;
    pulse_clr;
    chk("pdf clear", power_down_flag, 1'b0);
    for (k = 0; k < 3; k++) begin
      ien <= (k > 0) ? 4'h2 : 4'h0; sfull <= (k == 2);
      lcden <= (k == 1);
      wrc <= (k != 2);
      do_halt;
      chk("halt lcd", lcd, k == 1);
      chk("halt wdt", {wrun, wclr}, (k != 2) ? 2'b11 : 2'b00);
      @(posedge i_mclk); ireq <= 4'h2;
      wake;
      chk("int wake", {sr, si}, (k == 1) ? 2'b01 : 2'b10);
      ireq <= 4'h0;
    end
    wrc <= 1;
    do_halt;
    chk("halt wdt clear", wclr, 1'b1);
    @(posedge i_mclk); wdt <= 1;
    wake;
    chk("warm reset", {sw, crst}, 2'b10);
    chk("wdt wake flags", {to, power_down_flag}, 2'b11);
    wdt <= 0;
    do_halt;
    @(posedge i_mclk); pin_n <= 0;
    step(5);
    chk("pin chip reset", crst, 1'b1);
    pin_n <= 1;
    wake;
    chk("pin wake flags", {to, power_down_flag}, 2'b01);
    pulse_clr;
    @(posedge i_mclk); wdt <= 1;
    step(8);
    chk("run wdt flags", {to, power_down_flag}, 2'b10);
    wdt <= 0;
    @(posedge i_mclk); pin_n <= 0;
    step(5);
    pin_n <= 1;
    step(6);
    chk("run pin flags", {to, power_down_flag}, 2'b10);
    stop_test;
  end
endmodule
